//--- rps_sequencer.sv
`timescale 1ns/1ps
`include "rps_params.svh"
module rps_sequencer #(
   parameter int POWERUP_TIMER_TICKS = `RPS_POWERUP_TIMER_TICKS
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port
   input  wire rps_pkg::rps_addr_t reg_addr,
   input  wire rps_pkg::rps_data_t reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output rps_pkg::rps_data_t reg_rdata,
   // Pins and analog monitors
   input  wire logic       master_clear_n,
   input  wire logic       osc_input_pin,
   input  wire logic       rc_osc_clk,
   input  wire logic       por_detect,
   input  wire logic       brownout_detect,
   // Core side
   input  wire logic       watchdog_timer_expired,
   input  wire logic       sleep_active,
   output logic            core_reset,
   output logic            reg_reset,
   output logic            wake_resume,
   output rps_pkg::rps_kind_t reset_kind,
   output logic            timeout_flag,
   output logic            powerdown_flag,
   // Interrupt
   output logic            irq
);
   import rps_pkg::*;

   typedef struct packed {
      rps_state_t           st;
      rps_kind_t            kind;
      logic                 powerup_timer_pend;
      logic                 ost_pend;
      logic                 powerup_timer_go;
      logic                 ost_go;
      logic                 core_reset;
      logic                 reg_reset;
      logic                 wake_resume;
      logic                 to;
      logic                 pd;
      logic [1:0]           osc_sel;
      logic                 powerup_timer_dis;
      logic                 bor_en;
      logic [`RPS_EVT_W-1:0] evt;
      logic [`RPS_EVT_W-1:0] mask;
      rps_data_t            rdata;
      logic                 irq;
      logic                 rc_prev;
      logic                 osc_prev;
      logic                 master_clear_n_prev;
      logic                 por_prev;
      logic                 bor_prev;
   } rps_top_t;

   localparam rps_count_t POWERUP_TIMER_LIMIT = 16'(POWERUP_TIMER_TICKS);
   localparam rps_count_t OST_LIMIT  = 16'(`RPS_OST_CYCLES);

   rps_top_t r_reg;
   rps_top_t r_next;

   logic master_clear_n_f;
   logic osc_f;
   logic rc_f;
   logic por_f;
   logic bor_f;

   rps_timer_if powerup_timer_if ();
   rps_timer_if ost_if ();

   // Master-clear glitch filter
   rps_pin_filter #(.CYCLES(`RPS_MASTER_CLEAR_N_FILT_CYC), .INIT(1'b1)) u_master_clear_n_flt (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (master_clear_n),
      .level (master_clear_n_f)
   );

   // Oscillator pin synchroniser, crystal or external clock alike
   rps_pin_filter #(.CYCLES(`RPS_SYNC_FILT_CYC), .INIT(1'b0)) u_osc_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (osc_input_pin),
      .level (osc_f)
   );

   // Internal RC oscillator synchroniser
   rps_pin_filter #(.CYCLES(`RPS_SYNC_FILT_CYC), .INIT(1'b0)) u_rc_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (rc_osc_clk),
      .level (rc_f)
   );

   // Supply detector synchroniser
   rps_pin_filter #(.CYCLES(`RPS_SYNC_FILT_CYC), .INIT(1'b0)) u_por_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (por_detect),
      .level (por_f)
   );

   // Brown-out comparator synchroniser
   rps_pin_filter #(.CYCLES(`RPS_SYNC_FILT_CYC), .INIT(1'b0)) u_bor_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (brownout_detect),
      .level (bor_f)
   );

   // Power-up timer counts RC oscillator ticks
   assign powerup_timer_if.start = r_reg.powerup_timer_go;
   assign powerup_timer_if.tick  = rc_f & ~r_reg.rc_prev;
   assign powerup_timer_if.limit = POWERUP_TIMER_LIMIT;

   rps_tick_counter u_powerup_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .tmr   (powerup_timer_if.cnt)
   );

   // Start-up timer counts oscillator input rising edges
   assign ost_if.start = r_reg.ost_go;
   assign ost_if.tick  = osc_f & ~r_reg.osc_prev;
   assign ost_if.limit = OST_LIMIT;

   rps_tick_counter u_ost (
      .clk   (clk),
      .rst_n (rst_n),
      .tmr   (ost_if.cnt)
   );

   // Sequencer, flags and register port
   always_comb begin
      logic                  crystal;
      logic                  powerup_timer_on;
      logic                  bor_low;
      logic [`RPS_EVT_W-1:0] set_v;
      logic [`RPS_EVT_W-1:0] clr_v;
      crystal = (r_reg.osc_sel != `RPS_OSC_RC);
      powerup_timer_on = ~r_reg.powerup_timer_dis | r_reg.bor_en;
      bor_low = bor_f & r_reg.bor_en;
      set_v   = '0;
      clr_v   = '0;

      r_next             = r_reg;
      r_next.reg_reset   = 1'b0;
      r_next.wake_resume = 1'b0;
      r_next.powerup_timer_go     = 1'b0;
      r_next.ost_go      = 1'b0;
      r_next.rdata       = '0;
      r_next.rc_prev     = rc_f;
      r_next.osc_prev    = osc_f;
      r_next.master_clear_n_prev   = master_clear_n_f;
      r_next.por_prev    = por_f;
      r_next.bor_prev    = bor_low;

      // Timed release path
      unique case (r_reg.st)
         RPS_ST_HOLD: begin
            r_next.core_reset = 1'b1;
            if (r_reg.powerup_timer_pend && powerup_timer_on) begin
               r_next.st      = RPS_ST_POWERUP_TIMER;
               r_next.powerup_timer_go = 1'b1;
            end else if (r_reg.ost_pend && crystal) begin
               r_next.st      = RPS_ST_OST;
               r_next.ost_go  = 1'b1;
            end else begin
               r_next.st         = RPS_ST_RUN;
               r_next.core_reset = 1'b0;
               r_next.powerup_timer_pend  = 1'b0;
               r_next.ost_pend   = 1'b0;
            end
         end
         RPS_ST_POWERUP_TIMER: begin
            if (powerup_timer_if.done) begin
               r_next.powerup_timer_pend = 1'b0;
               r_next.st        = RPS_ST_HOLD;
            end
         end
         RPS_ST_OST: begin
            if (ost_if.done) begin
               r_next.ost_pend = 1'b0;
               r_next.st       = RPS_ST_HOLD;
            end
         end
         RPS_ST_WAKE: begin
            if (ost_if.done) begin
               r_next.st          = RPS_ST_RUN;
               r_next.wake_resume = 1'b1;
            end
         end
         RPS_ST_RUN: begin
            r_next.core_reset = 1'b0;
         end
      endcase

      // Reset causes, highest priority first
      if (por_f && !r_reg.por_prev) begin
         r_next.kind = RPS_KIND_POR;
         r_next.to   = 1'b1;
         r_next.pd   = 1'b1;
         r_next.powerup_timer_pend = 1'b1;
         r_next.ost_pend  = 1'b1;
         r_next.reg_reset = 1'b1;
         set_v[`RPS_EVT_POR] = 1'b1;
      end else if (bor_low && !r_reg.bor_prev) begin
         r_next.kind = RPS_KIND_BOR;
         r_next.to   = 1'b1;
         r_next.pd   = 1'b1;
         r_next.powerup_timer_pend = 1'b1;
         r_next.ost_pend  = 1'b0;
         r_next.reg_reset = 1'b1;
         set_v[`RPS_EVT_BOR] = 1'b1;
      end else if (!master_clear_n_f && r_reg.master_clear_n_prev) begin
         if (sleep_active) begin
            r_next.kind = RPS_KIND_MASTER_CLEAR_N_SLEEP;
            r_next.to   = 1'b1;
            r_next.pd   = 1'b0;
            set_v[`RPS_EVT_MASTER_CLEAR_N_SLEEP] = 1'b1;
         end else begin
            r_next.kind = RPS_KIND_MASTER_CLEAR_N_RUN; // flags unchanged
            set_v[`RPS_EVT_MASTER_CLEAR_N_RUN] = 1'b1;
         end
         r_next.powerup_timer_pend = 1'b0;
         r_next.ost_pend  = 1'b0;
         r_next.reg_reset = 1'b1;
      end else if (watchdog_timer_expired && r_reg.st == RPS_ST_RUN) begin
         if (sleep_active) begin
            r_next.kind = RPS_KIND_WDT_WAKE;
            r_next.to   = 1'b0;
            r_next.pd   = 1'b0;
            set_v[`RPS_EVT_WDT_WAKE] = 1'b1;
            if (crystal) begin
               r_next.st     = RPS_ST_WAKE;
               r_next.ost_go = 1'b1;
            end else begin
               r_next.wake_resume = 1'b1;
            end
         end else begin
            r_next.kind = RPS_KIND_WDT_RESET;
            r_next.to   = 1'b0;
            r_next.pd   = 1'b1;
            r_next.reg_reset  = 1'b1;
            r_next.core_reset = 1'b1;
            r_next.st   = RPS_ST_HOLD;
            set_v[`RPS_EVT_WDT_RST] = 1'b1;
         end
      end

      // Any reset cause, a low master-clear or brown-out holds the core
      if (r_next.reg_reset || !master_clear_n_f || bor_low) begin
         r_next.st         = RPS_ST_HOLD;
         r_next.core_reset = 1'b1;
      end

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            `RPS_OFS_CONFIG: begin
               r_next.osc_sel  = reg_wdata[`RPS_CFG_OSC_HI:`RPS_CFG_OSC_LO];
               r_next.powerup_timer_dis = reg_wdata[`RPS_CFG_POWERUP_TIMER_DIS];
               r_next.bor_en   = reg_wdata[`RPS_CFG_BOR_EN];
            end
            `RPS_OFS_EVENT: clr_v = reg_wdata[`RPS_EVT_W-1:0];
            `RPS_OFS_MASK:  r_next.mask = reg_wdata[`RPS_EVT_W-1:0];
            default: ;
         endcase
      end

      // Sticky events, a new event beats the clear
      r_next.evt = (r_reg.evt & ~clr_v) | set_v;
      r_next.irq = |(r_next.evt & r_next.mask);

      // Register reads, data one cycle later
      if (reg_rd) begin
         unique case (reg_addr)
            `RPS_OFS_CONFIG: r_next.rdata = {28'h0000000, r_reg.bor_en, r_reg.powerup_timer_dis, r_reg.osc_sel};
            `RPS_OFS_FLAGS:  r_next.rdata = {26'h0000000, r_reg.core_reset, r_reg.kind, r_reg.to, r_reg.pd};
            `RPS_OFS_EVENT:  r_next.rdata = {26'h0000000, r_reg.evt};
            `RPS_OFS_MASK:   r_next.rdata = {26'h0000000, r_reg.mask};
            default:         r_next.rdata = 32'h00000000;
         endcase
      end
   end

   // State register; config and flags reset only by rst_n, never by the core resets
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_reg            <= '0;
         r_reg.st         <= RPS_ST_HOLD;
         r_reg.kind       <= RPS_KIND_POR;
         r_reg.powerup_timer_pend  <= 1'b1;
         r_reg.ost_pend   <= 1'b1;
         r_reg.core_reset <= 1'b1;
         r_reg.reg_reset  <= 1'b1;
         r_reg.to         <= 1'b1;
         r_reg.pd         <= 1'b1;
         r_reg.osc_sel    <= 2'(`RPS_CFG_RESET >> `RPS_CFG_OSC_LO);
         r_reg.powerup_timer_dis   <= 1'b1;
         r_reg.bor_en     <= 1'b1;
         r_reg.master_clear_n_prev  <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata      = r_reg.rdata;
   assign core_reset     = r_reg.core_reset;
   assign reg_reset      = r_reg.reg_reset;
   assign wake_resume    = r_reg.wake_resume;
   assign reset_kind     = r_reg.kind;
   assign timeout_flag   = r_reg.to;
   assign powerdown_flag = r_reg.pd;
   assign irq            = r_reg.irq;
endmodule : rps_sequencer

//--- rps_params.svh
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// Clock and timing
`define RPS_CLK_PERIOD_NS   20
`define RPS_MASTER_CLEAR_N_FILT_NS    200
`define RPS_MASTER_CLEAR_N_FILT_CYC   ((`RPS_MASTER_CLEAR_N_FILT_NS + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS)
`define RPS_POWERUP_TIMER_MS         72
`define RPS_RC_PERIOD_US    32
`define RPS_POWERUP_TIMER_TICKS      ((`RPS_POWERUP_TIMER_MS * 1000) / `RPS_RC_PERIOD_US)
`define RPS_OST_CYCLES      1024
`define RPS_SYNC_FILT_CYC   1

// Register offsets
`define RPS_OFS_CONFIG      8'h00
`define RPS_OFS_FLAGS       8'h04
`define RPS_OFS_EVENT       8'h08
`define RPS_OFS_MASK        8'h0C

// CONFIG fields
`define RPS_CFG_OSC_LO      0
`define RPS_CFG_OSC_HI      1
`define RPS_CFG_POWERUP_TIMER_DIS    2
`define RPS_CFG_BOR_EN      3
`define RPS_CFG_RESET       4'hF

// Oscillator mode codes
`define RPS_OSC_LP          2'h0
`define RPS_OSC_XT          2'h1
`define RPS_OSC_HS          2'h2
`define RPS_OSC_RC          2'h3

// FLAGS fields
`define RPS_FLG_PD          0
`define RPS_FLG_TO          1
`define RPS_FLG_KIND_LO     2
`define RPS_FLG_CORE_RST    5

// Event bits
`define RPS_EVT_POR         0
`define RPS_EVT_MASTER_CLEAR_N_RUN    1
`define RPS_EVT_MASTER_CLEAR_N_SLEEP  2
`define RPS_EVT_WDT_RST     3
`define RPS_EVT_WDT_WAKE    4
`define RPS_EVT_BOR         5
`define RPS_EVT_W           6

`endif

//--- rps_pkg.sv
package rps_pkg;

   typedef enum logic [2:0] {
      RPS_KIND_NONE,
      RPS_KIND_POR,
      RPS_KIND_MASTER_CLEAR_N_RUN,
      RPS_KIND_MASTER_CLEAR_N_SLEEP,
      RPS_KIND_WDT_RESET,
      RPS_KIND_WDT_WAKE,
      RPS_KIND_BOR
   } rps_kind_t;

   typedef enum logic [2:0] {
      RPS_ST_HOLD,
      RPS_ST_POWERUP_TIMER,
      RPS_ST_OST,
      RPS_ST_WAKE,
      RPS_ST_RUN
   } rps_state_t;

   typedef logic [7:0]  rps_addr_t;
   typedef logic [31:0] rps_data_t;
   typedef logic [15:0] rps_count_t;

endpackage : rps_pkg

//--- rps_timer_if.sv
`timescale 1ns/1ps
interface rps_timer_if;
   import rps_pkg::*;
   logic       start;
   logic       tick;
   rps_count_t limit;
   logic       done;

   modport ctrl (output start, output tick, output limit, input done);
   modport cnt  (input start, input tick, input limit, output done);
endinterface : rps_timer_if

//--- rps_pin_filter.sv
`timescale 1ns/1ps
module rps_pin_filter #(
   parameter int   CYCLES = 1,
   parameter logic INIT   = 1'b0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pin and clean level
   input  wire logic pin,
   output logic      level
);
   import rps_pkg::*;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic [7:0] cnt;
      logic       out;
   } rps_flt_t;

   localparam logic [7:0] LAST = 8'(CYCLES - 1);

   rps_flt_t r_reg;
   rps_flt_t r_next;

   // Two-flop synchroniser, then a level must stand CYCLES cycles
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = pin;
      r_next.s2 = r_reg.s1;
      if (r_reg.s2 == r_reg.out) begin
         r_next.cnt = 8'h00;
      end else if (r_reg.cnt == LAST) begin
         r_next.out = r_reg.s2;
         r_next.cnt = 8'h00;
      end else begin
         r_next.cnt = r_reg.cnt + 8'h01;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_reg <= '{s1: INIT, s2: INIT, cnt: 8'h00, out: INIT};
      end else begin
         r_reg <= r_next;
      end
   end

   assign level = r_reg.out;
endmodule : rps_pin_filter

//--- rps_tick_counter.sv
`timescale 1ns/1ps
module rps_tick_counter (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // Timer control
   rps_timer_if.cnt   tmr
);
   import rps_pkg::*;

   typedef struct packed {
      rps_count_t cnt;
      logic       busy;
      logic       done;
   } rps_cnt_t;

   rps_cnt_t r_reg;
   rps_cnt_t r_next;

   // Counts ticks after start; one-cycle done at the terminal count
   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      if (tmr.start) begin
         r_next.cnt  = '0;
         r_next.busy = 1'b1;
      end else if (r_reg.busy && tmr.tick) begin
         if (r_reg.cnt == tmr.limit - 16'h0001) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end
         r_next.cnt = r_reg.cnt + 16'h0001;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tmr.done = r_reg.done;
endmodule : rps_tick_counter

//--- rps_seq_asserts.sv
`timescale 1ns/1ps
module rps_seq_asserts #(
   parameter int POWERUP_TIMER_TICKS = 4
) (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst_n,
   // Inputs of the block
   input wire logic               master_clear_n,
   input wire logic               watchdog_timer_expired,
   // Sequencer outputs
   input wire logic               core_reset,
   input wire logic               reg_reset,
   input wire logic               wake_resume,
   input wire rps_pkg::rps_kind_t reset_kind,
   input wire logic               timeout_flag,
   input wire logic               powerdown_flag
);
   import rps_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [4:0] low_cnt;

   // Length of the present low level on the master-clear pin
   always_ff @(posedge clk) begin
      if (!rst_n || master_clear_n) begin
         low_cnt <= 5'h00;
      end else if (low_cnt != 5'h1F) begin
         low_cnt <= low_cnt + 5'h01;
      end
   end

   // Short low pulse, the absence of a master-clear reset, and a watchdog reset
   sequence s_glitch;
      master_clear_n ##1 !master_clear_n [*3] ##1 master_clear_n;
   endsequence
   sequence s_no_master_clear_n;
      !(reg_reset && (reset_kind == RPS_KIND_MASTER_CLEAR_N_RUN || reset_kind == RPS_KIND_MASTER_CLEAR_N_SLEEP));
   endsequence
   sequence s_wdt_rst;
      reg_reset && reset_kind == RPS_KIND_WDT_RESET;
   endsequence

   property p_glitch;
      s_glitch |=> s_no_master_clear_n [*8] ##1 s_no_master_clear_n [*8];
   endproperty
   property p_master_clear_n_hold;
      low_cnt >= 5'h12 |-> core_reset;
   endproperty
   property p_regrst_pulse;
      reg_reset |=> !reg_reset;
   endproperty
   property p_regrst_core;
      reg_reset |-> core_reset;
   endproperty
   property p_wake_quiet;
      wake_resume |-> !reg_reset && !core_reset;
   endproperty
   property p_wake_flags;
      wake_resume |-> reset_kind == RPS_KIND_WDT_WAKE && !timeout_flag && !powerdown_flag;
   endproperty
   property p_por_flags;
      reg_reset && (reset_kind == RPS_KIND_POR || reset_kind == RPS_KIND_BOR) |-> timeout_flag && powerdown_flag;
   endproperty
   property p_mslp_flags;
      reg_reset && reset_kind == RPS_KIND_MASTER_CLEAR_N_SLEEP |-> timeout_flag && !powerdown_flag;
   endproperty
   property p_wdt_rst;
      s_wdt_rst |-> !timeout_flag && powerdown_flag ##2 !core_reset;
   endproperty
   property p_wdt_gate;
      core_reset && watchdog_timer_expired |=> !(reg_reset && reset_kind == RPS_KIND_WDT_RESET) && !wake_resume;
   endproperty

   a_glitch: assert property (p_glitch) else $error("short low pulse caused a reset");
   a_master_clear_n_hold: assert property (p_master_clear_n_hold) else $error("held master-clear left core running");
   a_regrst_pulse: assert property (p_regrst_pulse) else $error("register reset longer than one cycle");
   a_regrst_core: assert property (p_regrst_core) else $error("register reset without core reset");
   a_wake_quiet: assert property (p_wake_quiet) else $error("wake-up disturbed registers or core");
   a_wake_flags: assert property (p_wake_flags) else $error("wrong flags on wake-up");
   a_por_flags: assert property (p_por_flags) else $error("wrong flags on power or supply reset");
   a_mslp_flags: assert property (p_mslp_flags) else $error("wrong flags on reset in sleep");
   a_wdt_rst: assert property (p_wdt_rst) else $error("wrong watchdog reset sequence");
   a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog acted while core held");
endmodule : rps_seq_asserts

//--- rps_far_model.sv
`timescale 1ns/1ps
module rps_far_model #(
   parameter int RC_HALF_NS  = 97,
   parameter int OSC_HALF_NS = 61
) (
   // Requests from the bench
   input  wire logic hold_master_clear_n,
   input  wire logic supply_low,
   input  wire logic power_up,
   // Pins towards the device
   output logic      master_clear_n,
   output logic      por_detect,
   output logic      brownout_detect,
   output logic      rc_osc_clk,
   output logic      osc_input_pin
);
   // Pin pulled up unless the outside switch holds the device in reset
   assign master_clear_n = !hold_master_clear_n;
   // Supply monitor: rising supply and low supply
   assign por_detect      = power_up;
   assign brownout_detect = supply_low;

   // Free-running internal RC oscillator
   initial begin
      rc_osc_clk = 1'b0;
      forever #(RC_HALF_NS) rc_osc_clk = ~rc_osc_clk;
   end

   // External clock driven into the oscillator input
   initial begin
      osc_input_pin = 1'b0;
      forever #(OSC_HALF_NS) osc_input_pin = ~osc_input_pin;
   end
endmodule : rps_far_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   import rps_pkg::*;
   localparam int POWERUP_TIMER_T   = 4;
   localparam int RC_HALF  = 97;
   localparam int OSC_HALF = 61;
   logic       clk, rst_n, reg_wr, reg_rd, watchdog_timer_expired, sleep_active, irq;
   logic       master_clear_n, osc_input_pin, rc_osc_clk, por_detect, brownout_detect;
   logic       core_reset, reg_reset, wake_resume, timeout_flag, powerdown_flag;
   logic       hold_master_clear_n, supply_low, power_up;
   logic [1:0] m;
   rps_addr_t  reg_addr;
   rps_data_t  reg_wdata, reg_rdata;
   rps_kind_t  reset_kind;
   int         n_errors, checks, n, len, base;

   rps_sequencer #(.POWERUP_TIMER_TICKS(POWERUP_TIMER_T)) i_dut (
      .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .master_clear_n, .osc_input_pin,
      .rc_osc_clk, .por_detect, .brownout_detect, .watchdog_timer_expired, .sleep_active, .core_reset,
      .reg_reset, .wake_resume, .reset_kind, .timeout_flag, .powerdown_flag, .irq);
   rps_far_model #(.RC_HALF_NS(RC_HALF), .OSC_HALF_NS(OSC_HALF)) i_far (
      .hold_master_clear_n, .supply_low, .power_up, .master_clear_n, .por_detect, .brownout_detect, .rc_osc_clk,
      .osc_input_pin);

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Expected flag word and shortest legal delays
   function automatic rps_data_t flg(input rps_kind_t k, input logic t, input logic p);
      return {26'h0000000, 1'b0, k, t, p};
   endfunction : flg
   function automatic int min_cyc(input int ticks, input int half_ns);
      return (ticks - 1) * 2 * half_ns / 20;
   endfunction : min_cyc

   // Compare tasks
   task automatic chk_w(input rps_data_t got, input rps_data_t exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk_w
   task automatic chk_b(input logic got, input logic exp);
      chk_w({31'h00000000, got}, {31'h00000000, exp});
   endtask : chk_b

   // Register bus cycles
   task automatic wr(input rps_addr_t a, input rps_data_t v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic chk_rd(input rps_addr_t a, input rps_data_t e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk_w(reg_rdata, e);
   endtask : chk_rd

   // Pin and core stimulus
   task automatic hold(input int c);
      @(posedge clk);
      hold_master_clear_n <= 1'b1;
      repeat (c) @(posedge clk);
      hold_master_clear_n <= 1'b0;
   endtask : hold
   task automatic pulse_wdt();
      @(posedge clk);
      watchdog_timer_expired <= 1'b1;
      @(posedge clk);
      watchdog_timer_expired <= 1'b0;
   endtask : pulse_wdt
   task automatic wait_cr(input logic v, output int c);
      c = 0;
      while (core_reset !== v && c < 20000) begin
         @(negedge clk);
         c++;
      end
      chk_b(core_reset, v);
   endtask : wait_cr

   task automatic results();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // Hang guard
   initial begin
      #(60000 * 20);
      n_errors++;
      results();
   end

   // Main sequence
   initial begin
      void'($urandom(32'hBCD0));
      {rst_n, reg_wr, reg_rd, watchdog_timer_expired, sleep_active, hold_master_clear_n, supply_low, power_up} = '0;
      reg_addr  = '0;
      reg_wdata = '0;
      n_errors  = 0;
      checks    = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      wait_cr(1'b0, n);
      chk_b(n >= min_cyc(POWERUP_TIMER_T, RC_HALF), 1'b1);
      chk_rd(8'h04, flg(RPS_KIND_POR, 1'b1, 1'b1));
      chk_rd(8'h00, 32'h0000000F);
      chk_rd(8'h08, 32'h00000000);
      chk_rd(8'h0C, 32'h00000000);
      chk_rd(8'h10, 32'h00000000);
      wr(8'h04, 32'hFFFFFFFF);
      chk_rd(8'h04, flg(RPS_KIND_POR, 1'b1, 1'b1));
      // Releasing rst_n records no event, so an open mask leaves the interrupt low
      chk_b(irq, 1'b0);
      wr(8'h0C, 32'h0000003F);
      chk_rd(8'h0C, 32'h0000003F);
      chk_b(irq, 1'b0);
      // Power-on with the delay disabled and brown-out off
      wr(8'h00, 32'h00000007);
      @(posedge clk);
      power_up <= 1'b1;
      repeat (3) @(posedge clk);
      power_up <= 1'b0;
      wait_cr(1'b1, n);
      wait_cr(1'b0, n);
      chk_b(n < 20, 1'b1);
      chk_rd(8'h04, flg(RPS_KIND_POR, 1'b1, 1'b1));
      // Power-on event raises the interrupt; writing a one clears it
      chk_rd(8'h08, 32'h00000001);
      chk_b(irq, 1'b1);
      wr(8'h08, 32'h00000001);
      chk_rd(8'h08, 32'h00000000);
      chk_b(irq, 1'b0);
      // Short master-clear pulses are ignored
      for (int i = 0; i < 4; i++) begin
         len = (i == 0) ? 3 : 1 + $urandom_range(4);
         hold(len);
         repeat (20) @(negedge clk);
         chk_b(core_reset, 1'b0);
         chk_rd(8'h04, flg(RPS_KIND_POR, 1'b1, 1'b1));
      end
      pulse_wdt();
      repeat (4) @(negedge clk);
      chk_rd(8'h04, flg(RPS_KIND_WDT_RESET, 1'b0, 1'b1));
      // Master-clear held, watchdog ignored meanwhile
      len = 20 + $urandom_range(30);
      @(posedge clk);
      hold_master_clear_n <= 1'b1;
      repeat (len) @(posedge clk);
      pulse_wdt();
      @(negedge clk);
      chk_b(core_reset, 1'b1);
      @(posedge clk);
      hold_master_clear_n <= 1'b0;
      wait_cr(1'b0, n);
      chk_rd(8'h04, flg(RPS_KIND_MASTER_CLEAR_N_RUN, 1'b0, 1'b1));
      @(posedge clk);
      sleep_active <= 1'b1;
      hold(25);
      sleep_active <= 1'b0;
      wait_cr(1'b0, n);
      chk_rd(8'h04, flg(RPS_KIND_MASTER_CLEAR_N_SLEEP, 1'b1, 1'b0));
      // Brown-out forces the power-up delay on
      wr(8'h00, 32'h0000000F);
      @(posedge clk);
      supply_low <= 1'b1;
      repeat (10) @(posedge clk);
      supply_low <= 1'b0;
      @(negedge clk);
      chk_b(core_reset, 1'b1);
      wait_cr(1'b0, n);
      chk_b(n >= min_cyc(POWERUP_TIMER_T, RC_HALF), 1'b1);
      chk_rd(8'h04, flg(RPS_KIND_BOR, 1'b1, 1'b1));
      // Watchdog wake-up in every oscillator mode
      base = $urandom_range(3);
      for (int i = 0; i < 4; i++) begin
         m = 2'((base + i) % 4);
         wr(8'h00, {28'h0000000, 2'b01, m});
         @(posedge clk);
         sleep_active <= 1'b1;
         pulse_wdt();
         n = 0;
         while (wake_resume !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
         end
         chk_b(core_reset, 1'b0);
         chk_b((m == 2'h3) ? n < 8 : (n >= min_cyc(1024, OSC_HALF) && n < 20000), 1'b1);
         @(posedge clk);
         sleep_active <= 1'b0;
         chk_rd(8'h04, flg(RPS_KIND_WDT_WAKE, 1'b0, 1'b0));
         chk_w({29'h00000000, reset_kind}, {29'h00000000, RPS_KIND_WDT_WAKE});
         chk_b(timeout_flag | powerdown_flag, 1'b0);
      end
      chk_rd(8'h08, 32'h0000003E);
      chk_b(irq, 1'b1);
      wr(8'h0C, 32'h00000000);
      chk_rd(8'h0C, 32'h00000000);
      chk_b(irq, 1'b0);
      results();
   end
endmodule : testbench

bind rps_sequencer rps_seq_asserts #(.POWERUP_TIMER_TICKS(POWERUP_TIMER_TICKS)) i_chk (
   .clk, .rst_n, .master_clear_n, .watchdog_timer_expired, .core_reset, .reg_reset, .wake_resume,
   .reset_kind, .timeout_flag, .powerdown_flag);
